// ### backend_pkg.sv
// constants, register map and shared decode for the output conditioning path
package backend_pkg;
   localparam int XW = 22;
   localparam int FIELD_W = 8;
   localparam int FIELD_MSB = 7;
   localparam int WORD_W = 32;
   localparam int LUT_DEPTH = 64;
   localparam int ADDR_W = 9;
   localparam int LATENCY = 3;

   // byte addresses on the register bus
   localparam logic [8:0] OFS_LUT_END = 9'h100;
   localparam logic [8:0] OFS_UPPER_SAT = 9'h100;
   localparam logic [8:0] OFS_LOWER_SAT = 9'h104;
   localparam logic [8:0] OFS_CTL2 = 9'h108;
   localparam logic [8:0] OFS_CTL3 = 9'h10C;
   localparam logic [8:0] OFS_ACCESS = 9'h110;
   localparam logic [8:0] OFS_MONITOR = 9'h114;
   localparam logic [8:0] OFS_STATUS = 9'h118;

   // field positions
   localparam int PRESCALE_LSB = 0;
   localparam int PRESCALE_W = 5;
   localparam logic [4:0] PRESCALE_MAX = 5'h10;
   localparam int LOWER_MUX_BIT = 5;
   localparam int UPPER_MUX_BIT = 6;
   localparam int ADD_Y_BIT = 1;
   localparam int DYN_BIT = 2;
   localparam int STATIC_LSB = 3;
   localparam int SHIFT_W = 5;
   localparam int Y_SHIFT_LSB = 22;
   localparam int CASC_OE_BIT = 0;
   localparam int TABLE_EN_BIT = 1;
   localparam int DELAY_OE_BIT = 2;
   localparam int MON_MAX_BIT = 0;
   localparam logic [1:0] SAT_BYTE = 2'h3;
   localparam logic [4:0] RIGHT_MAX = 5'h0E;
   localparam logic [4:0] LEFT_MAX = 5'h1E;

   // reset values
   localparam logic [31:0] CTL2_RST = 32'h0000_0000;
   localparam logic [31:0] CTL3_RST = 32'h0000_0000;
   localparam logic [31:0] ACCESS_RST = 32'h0000_0000;
   localparam logic [31:0] MONITOR_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_e;

   // codes 15..-3 zero the shifter output
   function automatic logic norm_code_zero(input logic [4:0] code);
      norm_code_zero = !((code <= RIGHT_MAX) || (code >= LEFT_MAX));
   endfunction
endpackage

// ### norm_if.sv
// carrier between the output path and its normalising shifter
`timescale 1ns/1ps
`default_nettype none
interface norm_if;
   logic [21:0] data_in;
   logic [4:0] shift_code;
   logic [21:0] data_out;
   modport requester(output data_in, output shift_code, input data_out);
   modport shifter(input data_in, input shift_code, output data_out);
endinterface
`default_nettype wire

// ### normaliser_shift.sv
// normalising shifter: rounded arithmetic right shift or left shift
`timescale 1ns/1ps
`default_nettype none
module normaliser_shift (
   norm_if.shifter nrm
);
   logic signed [22:0] wide;
   logic signed [22:0] shifted;
   logic [4:0] amt;

   always_comb begin
      wide = '0;
      shifted = '0;
      amt = '0;
      nrm.data_out = '0;
      if (backend_pkg::norm_code_zero(nrm.shift_code)) begin
         nrm.data_out = '0;
      end else if (nrm.shift_code[4]) begin
         // negative code: left shift by one or two, zeros enter low end
         amt = 5'(~nrm.shift_code + 5'h1);
         nrm.data_out = nrm.data_in << amt[1:0];
      end else if (nrm.shift_code == 5'h00) begin
         nrm.data_out = nrm.data_in;
      end else begin
         amt = nrm.shift_code;
         // extra bit keeps the half-lsb add from wrapping the sign
         wide = $signed({nrm.data_in[21], nrm.data_in})
            + $signed(23'h1 << (amt - 5'h1));
         shifted = wide >>> amt;
         nrm.data_out = shifted[21:0];
      end
   end
endmodule
`default_nettype wire

// ### backend_transform_normaliser.sv
// output conditioning path: prescaler, table, normaliser, output adder
`timescale 1ns/1ps
`default_nettype none
module backend_transform_normaliser (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [21:0] x_bus,
   input wire logic pos_overflow,
   input wire logic neg_overflow,
   input wire logic [8:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [21:0] cascade_out,
   output logic cascade_out_oe,
   output logic delay_line_oe,
   output logic monitor_max_mode
);
   localparam int NW = backend_pkg::WORD_W;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] wdata, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = wdata[8*b +: 8];
         end
      end
      merge_bytes = res;
   endfunction

   backend_pkg::bus_state_e bus_state_reg;
   logic [31:0] backend_control_two_reg;
   logic [31:0] backend_control_three_reg;
   logic [31:0] access_control_word_reg;
   logic [31:0] monitor_control_reg;
   logic [NW-1:0] upper_saturation_word;
   logic [NW-1:0] lower_saturation_word;
   logic [NW-1:0] table_mem [0:backend_pkg::LUT_DEPTH-1];
   logic [31:0] read_next;
   logic bus_write_ack;
   logic lut_hit;
   logic table_en;

   logic [4:0] pre_amt;
   logic [21:0] pre_shifted;
   logic [7:0] field;
   logic sel_err;

   logic [5:0] addr_s1;
   logic [1:0] byte_s1;
   logic sat_upper_s1;
   logic sat_lower_s1;
   logic sel_err_s1;
   logic pos_s1;
   logic neg_s1;
   logic [21:0] x_s1;

   logic [NW-1:0] y_s2;
   logic [1:0] byte_s2;
   logic [21:0] x_s2;
   logic [7:0] table_byte;
   logic [21:0] sum;

   norm_if norm ();

   normaliser_shift u_shift (
      .nrm(norm.shifter)
   );

   assign table_en = access_control_word_reg[backend_pkg::TABLE_EN_BIT];
   assign bus_write_ack = (bus_state_reg == backend_pkg::BUS_ACK) && write;
   assign lut_hit = address < backend_pkg::OFS_LUT_END;

   // register bus handshake: one wait cycle, answer on the second edge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_state_reg <= backend_pkg::BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else begin
         case (bus_state_reg)
            backend_pkg::BUS_IDLE: begin
               if (read || write) begin
                  bus_state_reg <= backend_pkg::BUS_ACK;
                  waitrequest <= 1'b0;
                  readdata <= read ? read_next : 32'h0000_0000;
               end
            end
            backend_pkg::BUS_ACK: begin
               bus_state_reg <= backend_pkg::BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               bus_state_reg <= backend_pkg::BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      read_next = 32'h0000_0000;
      if (lut_hit) begin
         // table is the host's only while the datapath is off it
         if (!table_en) begin
            read_next = table_mem[address[7:2]];
         end
      end else begin
         case (address)
            backend_pkg::OFS_UPPER_SAT: begin
               read_next = table_en ? 32'h0 : upper_saturation_word;
            end
            backend_pkg::OFS_LOWER_SAT: begin
               read_next = table_en ? 32'h0 : lower_saturation_word;
            end
            backend_pkg::OFS_CTL2: read_next = backend_control_two_reg;
            backend_pkg::OFS_CTL3: read_next = backend_control_three_reg;
            backend_pkg::OFS_ACCESS: read_next = access_control_word_reg;
            backend_pkg::OFS_MONITOR: read_next = monitor_control_reg;
            backend_pkg::OFS_STATUS: begin
               read_next = {27'h0, pos_s1, neg_s1, sel_err_s1,
                  sat_upper_s1, sat_lower_s1};
            end
            default: read_next = 32'h0000_0000;
         endcase
      end
   end

   // table and saturation words: no reset, contents undefined
   always_ff @(posedge sys_clk) begin
      if (bus_write_ack && !table_en) begin
         if (lut_hit) begin
            table_mem[address[7:2]] <= merge_bytes(table_mem[address[7:2]],
               writedata, byteenable);
         end
         if (address == backend_pkg::OFS_UPPER_SAT) begin
            upper_saturation_word <= merge_bytes(upper_saturation_word,
               writedata, byteenable);
         end
         if (address == backend_pkg::OFS_LOWER_SAT) begin
            lower_saturation_word <= merge_bytes(lower_saturation_word,
               writedata, byteenable);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         backend_control_two_reg <= backend_pkg::CTL2_RST;
         backend_control_three_reg <= backend_pkg::CTL3_RST;
         access_control_word_reg <= backend_pkg::ACCESS_RST;
         monitor_control_reg <= backend_pkg::MONITOR_RST;
      end else if (bus_write_ack) begin
         case (address)
            backend_pkg::OFS_CTL2: begin
               backend_control_two_reg <= merge_bytes(
                  backend_control_two_reg, writedata, byteenable);
            end
            backend_pkg::OFS_CTL3: begin
               backend_control_three_reg <= merge_bytes(
                  backend_control_three_reg, writedata, byteenable);
            end
            backend_pkg::OFS_ACCESS: begin
               access_control_word_reg <= merge_bytes(
                  access_control_word_reg, writedata, byteenable);
            end
            backend_pkg::OFS_MONITOR: begin
               monitor_control_reg <= merge_bytes(
                  monitor_control_reg, writedata, byteenable);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cascade_out_oe <= 1'b0;
         delay_line_oe <= 1'b0;
         monitor_max_mode <= 1'b0;
      end else begin
         cascade_out_oe <= access_control_word_reg[backend_pkg::CASC_OE_BIT];
         delay_line_oe <= access_control_word_reg[backend_pkg::DELAY_OE_BIT];
         monitor_max_mode <= monitor_control_reg[backend_pkg::MON_MAX_BIT];
      end
   end

   // prescaler: codes above 16 clamp rather than empty the field
   assign pre_amt = (backend_control_two_reg[4:0] > backend_pkg::PRESCALE_MAX)
      ? backend_pkg::PRESCALE_MAX : backend_control_two_reg[4:0];
   assign pre_shifted = 22'($signed(x_bus) >>> pre_amt);
   assign field = pre_shifted[backend_pkg::FIELD_MSB:0];
   // shifted bus is sign-filled, so checking bits 21..7 covers all
   assign sel_err = (|pre_shifted[21:backend_pkg::FIELD_MSB])
      && !(&pre_shifted[21:backend_pkg::FIELD_MSB]);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         addr_s1 <= 6'h00;
         byte_s1 <= 2'h0;
         sat_upper_s1 <= 1'b0;
         sat_lower_s1 <= 1'b0;
         sel_err_s1 <= 1'b0;
         pos_s1 <= 1'b0;
         neg_s1 <= 1'b0;
         x_s1 <= 22'h00_0000;
      end else begin
         addr_s1 <= field[7:2];
         byte_s1 <= (pos_overflow || neg_overflow || sel_err)
            ? backend_pkg::SAT_BYTE : field[1:0];
         // bus overflow direction wins over select direction
         sat_upper_s1 <= pos_overflow
            || (!neg_overflow && sel_err && !x_bus[21]);
         sat_lower_s1 <= !pos_overflow
            && (neg_overflow || (sel_err && x_bus[21]));
         sel_err_s1 <= sel_err;
         pos_s1 <= pos_overflow;
         neg_s1 <= neg_overflow;
         x_s1 <= x_bus;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         y_s2 <= 32'h0000_0000;
         byte_s2 <= 2'h0;
         x_s2 <= 22'h00_0000;
      end else begin
         if (!table_en) begin
            y_s2 <= 32'h0000_0000;
         end else if (sat_upper_s1) begin
            y_s2 <= upper_saturation_word;
         end else if (sat_lower_s1) begin
            y_s2 <= lower_saturation_word;
         end else begin
            y_s2 <= table_mem[addr_s1];
         end
         byte_s2 <= byte_s1;
         x_s2 <= x_s1;
      end
   end

   assign table_byte = y_s2[8*byte_s2 +: 8];
   assign norm.data_in = x_s2;
   // static field unless dynamic mode and table in use
   assign norm.shift_code = (table_en
      && backend_control_three_reg[backend_pkg::DYN_BIT])
      ? y_s2[backend_pkg::Y_SHIFT_LSB +: backend_pkg::SHIFT_W]
      : backend_control_three_reg[backend_pkg::STATIC_LSB +:
         backend_pkg::SHIFT_W];
   // wraps on overflow by design
   assign sum = norm.data_out + (backend_control_three_reg[
      backend_pkg::ADD_Y_BIT] ? y_s2[21:0] : 22'h00_0000);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cascade_out <= 22'h00_0000;
      end else begin
         cascade_out[21:14] <= backend_control_two_reg[
            backend_pkg::UPPER_MUX_BIT] ? table_byte : sum[21:14];
         cascade_out[13:8] <= sum[13:8];
         cascade_out[7:0] <= backend_control_two_reg[
            backend_pkg::LOWER_MUX_BIT] ? table_byte : sum[7:0];
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_ovf_upper;
      pos_overflow |=> sat_upper_s1 && !sat_lower_s1;
   endproperty
   a_ovf_upper: assert property (p_ovf_upper)
      else $error("positive overflow did not pick upper word");

   property p_ovf_priority;
      (neg_overflow && !pos_overflow && sel_err && !x_bus[21])
         |=> sat_lower_s1 && !sat_upper_s1;
   endproperty
   a_ovf_priority: assert property (p_ovf_priority)
      else $error("select error overrode bus overflow direction");

   property p_overselect;
      (!pos_overflow && !neg_overflow && sel_err && !x_bus[21])
         |=> sat_upper_s1 && byte_s1 == 2'h3;
   endproperty
   a_overselect: assert property (p_overselect)
      else $error("overselect did not pick upper word byte 3");

   property p_sat_byte;
      (pos_overflow || neg_overflow) |=> ##1 byte_s2 == 2'h3;
   endproperty
   a_sat_byte: assert property (p_sat_byte)
      else $error("overflow did not force byte 3");

   property p_table_addr;
      (!pos_overflow && !neg_overflow && !sel_err)
         |=> addr_s1 == $past(field[7:2]) && byte_s1 == $past(field[1:0]);
   endproperty
   a_table_addr: assert property (p_table_addr)
      else $error("table address or byte select wrong");

   property p_access_zero;
      !table_en |=> y_s2 == 32'h0000_0000;
   endproperty
   a_access_zero: assert property (p_access_zero)
      else $error("table word not zero with access bit low");

   property p_code_zero;
      backend_pkg::norm_code_zero(norm.shift_code) |-> norm.data_out == 22'h0;
   endproperty
   a_code_zero: assert property (p_code_zero)
      else $error("out of range shift code did not zero output");

   property p_round;
      (norm.shift_code == 5'h01 && norm.data_in == 22'h00_0003)
         |-> norm.data_out == 22'h00_0002;
   endproperty
   a_round: assert property (p_round)
      else $error("right shift did not round by half lsb");

   property p_left_fill;
      norm.shift_code == 5'h1F |-> norm.data_out == {norm.data_in[20:0], 1'b0};
   endproperty
   a_left_fill: assert property (p_left_fill)
      else $error("left shift by one wrong");

   property p_lower_mux;
      backend_control_two_reg[5] |=> cascade_out[7:0] == $past(table_byte);
   endproperty
   a_lower_mux: assert property (p_lower_mux)
      else $error("lower cascade byte not replaced by table byte");

   property p_upper_sat_load;
      (bus_write_ack && !table_en && address == 9'h100 && byteenable == 4'hF)
         |=> upper_saturation_word == $past(writedata);
   endproperty
   a_upper_sat_load: assert property (p_upper_sat_load)
      else $error("upper saturation word not loaded");

   property p_reset_float;
      $fell(sys_rst) |-> !cascade_out_oe && !delay_line_oe ##1 !cascade_out_oe;
   endproperty
   a_reset_float: assert property (p_reset_float)
      else $error("outputs enabled right after reset");
endmodule
`default_nettype wire

// ### cascade_source.sv
// upstream cascade sum source that drives the wrapped sum bus
`timescale 1ns/1ps
`default_nettype none
module cascade_source (
   input wire logic signed [22:0] sum,
   output logic [21:0] x_bus,
   output logic pos_overflow,
   output logic neg_overflow
);
   // the sum wraps onto the bus; the flags tell the device it is invalid
   always_comb begin
      x_bus = sum[21:0];
      pos_overflow = sum > 23'sd2097151;
      neg_overflow = sum < -23'sd2097152;
   end
endmodule
`default_nettype wire

// ### test_backend_transform_normaliser.sv
// self-checking bench for the output conditioning path
`timescale 1ns/1ps
`default_nettype none
module test_backend_transform_normaliser;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic signed [22:0] sum = '0;
   logic [21:0] x_bus;
   logic pos_overflow, neg_overflow, read = 1'b0, write = 1'b0;
   logic [8:0] address = '0;
   logic [31:0] writedata = '0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata, q, c2 = '0, c3 = '0, ac = '0;
   logic [31:0] tbl [64];
   logic [31:0] upper_sat = 32'hC07F_0123;
   logic [31:0] lower_sat = 32'h3F80_4567;
   logic waitrequest, cascade_out_oe, delay_line_oe, monitor_max_mode;
   logic [21:0] cascade_out;
   int errors = 0;
   int comparisons = 0;
   int sums [8] = '{37, -2000, 100000, -900000, 2097151, 3000000,
      -3000000, 700000};
   int pres [6] = '{0, 3, 8, 14, 16, 20};
   int codes [10] = '{0, 1, 2, 7, 14, 15, 16, 29, 30, 31};

   always #50 sys_clk = ~sys_clk;

   cascade_source src (.sum(sum), .x_bus(x_bus),
      .pos_overflow(pos_overflow), .neg_overflow(neg_overflow));
   backend_transform_normaliser uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .x_bus(x_bus), .pos_overflow(pos_overflow),
      .neg_overflow(neg_overflow), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .cascade_out(cascade_out), .cascade_out_oe(cascade_out_oe),
      .delay_line_oe(delay_line_oe), .monitor_max_mode(monitor_max_mode));

   task automatic fail(input logic [31:0] g, input logic [31:0] e);
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) fail(g, e);
   endtask
   task automatic chk22(input logic [21:0] g, input logic [21:0] e);
      comparisons++;
      if (g !== e) fail({10'h0, g}, {10'h0, e});
   endtask
   task automatic chk1(input logic g, input logic e);
      comparisons++;
      if (g !== e) fail({31'h0, g}, {31'h0, e});
   endtask

   // hold the request until waitrequest is sampled low, then release
   task automatic bus(input logic [8:0] a, input logic w,
         input logic [31:0] d, input logic [3:0] be);
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !w;
      write <= w;
      // read right at the edge: the values the slave had before it
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hF);
   endtask
   task automatic rd(input logic [8:0] a);
      bus(a, 1'b0, 32'h0, 4'hF);
   endtask
   task automatic cfg(input logic [31:0] a2, input logic [31:0] a3,
         input logic [31:0] aa);
      c2 = a2;
      c3 = a3;
      ac = aa;
      wr(backend_pkg::OFS_CTL2, a2);
      wr(backend_pkg::OFS_CTL3, a3);
      wr(backend_pkg::OFS_ACCESS, aa);
   endtask

   function automatic logic [21:0] model(input logic signed [22:0] s);
      logic [21:0] x, sh, n;
      logic po, ne, se;
      logic [4:0] p, code;
      logic [31:0] y;
      logic [7:0] f, b;
      logic [1:0] bs;
      logic signed [22:0] r;
      x = s[21:0];
      po = s > 23'sd2097151;
      ne = s < -23'sd2097152;
      p = (c2[4:0] > 5'h10) ? 5'h10 : c2[4:0];
      sh = $signed(x) >>> p;
      f = sh[7:0];
      se = sh[21:7] != {15{sh[7]}};
      y = po ? upper_sat : ne ? lower_sat
         : se ? (x[21] ? lower_sat : upper_sat) : tbl[f[7:2]];
      bs = (po | ne | se) ? 2'h3 : f[1:0];
      if (!ac[1]) y = '0;
      b = y[8*bs +: 8];
      code = (ac[1] && c3[2]) ? y[26:22] : c3[7:3];
      if (code <= 5'h0E) begin
         r = {x[21], x} + ((code == 5'h00) ? 23'h0 : (23'h1 << (code - 1)));
         r = r >>> code;
         n = r[21:0];
      end else if (code == 5'h1F) n = {x[20:0], 1'b0};
      else if (code == 5'h1E) n = {x[19:0], 2'b0};
      else n = '0;
      n = n + (c3[1] ? y[21:0] : 22'h0);
      if (c2[5]) n[7:0] = b;
      if (c2[6]) n[21:14] = b;
      return n;
   endfunction

   task automatic run(input int v);
      @(posedge sys_clk);
      sum <= 23'(v);
      repeat (3) @(posedge sys_clk);
      #1 chk22(cascade_out, model(23'(v)));
   endtask

   task automatic end_of_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #3_000_000;
      errors++;
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1 chk1(cascade_out_oe, 1'b0);
      chk1(delay_line_oe, 1'b0);
      chk1(monitor_max_mode, 1'b0);
      chk1(waitrequest, 1'b1);
      rd(backend_pkg::OFS_ACCESS);
      chk32(q, 32'h0);
      run(12345);
      // one new sample must take exactly three edges to appear
      @(posedge sys_clk);
      sum <= -23'sd777;
      repeat (2) @(posedge sys_clk);
      #1 chk22(cascade_out, model(23'sd12345));
      @(posedge sys_clk);
      #1 chk22(cascade_out, model(-23'sd777));
      for (int i = 0; i < 64; i++) begin
         tbl[i] = 32'(i) * 32'h0347_1D2B + 32'h0123_4567;
         wr(9'(4 * i), tbl[i]);
      end
      wr(backend_pkg::OFS_UPPER_SAT, upper_sat);
      wr(backend_pkg::OFS_LOWER_SAT, lower_sat);
      rd(9'h014);
      chk32(q, tbl[5]);
      rd(backend_pkg::OFS_LOWER_SAT);
      chk32(q, lower_sat);
      rd(9'h1FC);
      chk32(q, 32'h0);
      bus(backend_pkg::OFS_CTL2, 1'b1, 32'hFFFF_FF45, 4'h1);
      rd(backend_pkg::OFS_CTL2);
      chk32(q, 32'h0000_0045);
      cfg(32'h0, 32'h0, 32'h7);
      @(posedge sys_clk);
      #1 chk1(cascade_out_oe, 1'b1);
      chk1(delay_line_oe, 1'b1);
      rd(9'h014);
      chk32(q, 32'h0);
      wr(backend_pkg::OFS_MONITOR, 32'h1);
      @(posedge sys_clk);
      #1 chk1(monitor_max_mode, 1'b1);
      // static shifts, rounding, fill and wrap on the normaliser
      foreach (codes[k]) begin
         cfg(32'h0, 32'(codes[k]) << 3, 32'h3);
         run(-5);
         run(3);
         run(12345);
         run(2097151);
         run(-2097152);
      end
      // top field bit set with nothing above it: overselect in stage one
      run(200);
      rd(backend_pkg::OFS_STATUS);
      chk32(q, 32'h0000_0006);
      // table lookup, byte select, saturation and muxes
      for (int a = 0; a < 2; a++)
         for (int m = 0; m < 2; m++)
            foreach (pres[p]) begin
               cfg(32'(pres[p]) | (32'(p % 4) << 5), m ? 32'h7A : 32'h06,
                  a ? 32'h3 : 32'h1);
               foreach (sums[s])
                  run(sums[s]);
            end
      end_of_test();
   end
endmodule
`default_nettype wire
